// ===== design/wdog_pkg.sv
// Shared constants and types for the application watchdog and host power flags.
// Assumes an 8-bit register port driven by an I2C slave front end elsewhere.
package wdog_pkg;

    localparam logic [7:0] ADDR_ACTION_CFG  = 8'h23;
    localparam logic [7:0] ADDR_BOOT_GRACE  = 8'h24;
    localparam logic [7:0] ADDR_FLASH_COMMIT = 8'h25;
    localparam logic [7:0] ADDR_COUNTDOWN   = 8'h30;
    localparam logic [7:0] ADDR_HOST_UP     = 8'h31;

    localparam logic [7:0] ACTION_OFF       = 8'h00;
    localparam logic [7:0] ACTION_ALERT     = 8'h01;
    localparam logic [7:0] ACTION_HOST_HALT = 8'h02;

    localparam logic [7:0] RST_ACTION_CFG   = 8'h00;
    localparam logic [7:0] RST_BOOT_GRACE   = 8'h02;
    localparam logic [7:0] COMMIT_MAGIC     = 8'h46;
    localparam logic [7:0] ZERO_BYTE        = 8'h00;

    // Persistent image slots
    localparam int         NV_DEPTH         = 2;
    localparam logic [0:0] NV_SLOT_ACTION   = 1'h0;
    localparam logic [0:0] NV_SLOT_GRACE    = 1'h1;

    localparam int         CLOCK_HZ         = 20_000_000;
    localparam int         TICK_SECONDS     = 10;
    localparam int         TICK_CYCLES      = CLOCK_HZ * TICK_SECONDS;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        PAT_PULSE,
        PAT_STEADY,
        PAT_ERROR_FLASH
    } indicator_pattern_t;

endpackage

// ===== design/tick_divider.sv
// One-cycle enable every COUNT clock cycles.
// Assumes a single clock domain; runs freely from reset.
`timescale 1ns/100ps
module tick_divider
    import wdog_pkg::*;
#(
    parameter int COUNT = TICK_CYCLES
) (
    input  wire logic clock,
    input  wire logic arst_n,
    output logic      tick
);
    // A count below two would leave the enable stuck high
    if (COUNT < 2) begin : g_count_check
        $error("tick_divider COUNT too small");
    end

    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic        nxt_tick;
    logic        tick_ff;

    always_comb begin
        nxt_tick = 1'b0;
        nxt_cnt  = cnt_ff + 32'h0000_0001;
        if (cnt_ff == 32'(COUNT - 1)) begin
            nxt_cnt  = 32'h0000_0000;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff  <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule

// ===== design/nv_store.sv
// Small memory that holds the persistent configuration image.
// Read data is registered; contents survive only as long as the clocked store.
`timescale 1ns/100ps
module nv_store
    import wdog_pkg::*;
#(
    parameter int DEPTH = NV_DEPTH
) (
    input  wire logic                     clock,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [7:0]               wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [7:0]               rd_data
);
    if (DEPTH < 2) begin : g_depth_check
        $error("nv_store DEPTH too small");
    end

    logic [7:0] mem [DEPTH];
    logic [7:0] rd_ff;

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_ff <= mem[rd_addr];
    end

    assign rd_data = rd_ff;
endmodule

// ===== design/app_watchdog.sv
// Application watchdog and host power-state flag with flash commit.
// Assumes a register port from an I2C slave on the same clock; button,
// battery and shutdown-done inputs are pins and get synchronised here.
//
// Functional notes
// [R1] Countdown drops by one per 10 s tick and at zero runs the configured action.
// [R2] Action 0x00 disables actions and freezes the countdown.
// [R3] Action 0x01 on expiry replaces the indicator pattern with the error flash.
// [R4] Action 0x02 on expiry requests a host shutdown through the normal path.
// [R5] Host boot report loads the countdown from the grace value, default 2.
// [R6] A countdown write while enabled restarts it from the written value.
// [R7] Host application, not its daemon, rewrites the countdown regularly.
// [R8] Host-running flag stays 0 while power is off or the host boots.
// [R9] Daemon sets the flag to 1; indicator goes steady and the button is armed.
// [R10] Button press or low battery clears the flag; the daemon may clear it.
// [R11] Daemon starts a host shutdown when someone else clears the flag.
// [R12] During shutdown the indicator pulses; power drops once shutdown finishes.
// [R13] A software write of 0 to the flag starts a system shutdown.
// [R14] Writing 0x46 to the commit register stores persistent settings; else ignored.
// [R15] The commit register always reads 0.
// [R16] Only action and grace are stored; countdown and flag are not.
// [R17] After expiry the countdown stays at zero until rewritten or reloaded.
`timescale 1ns/100ps
module app_watchdog
    import wdog_pkg::*;
#(
    parameter int TICK_COUNT = TICK_CYCLES
) (
    input  wire logic               clock,
    input  wire logic               arst_n,
    input  wire reg_req_t           reg_req,
    output logic [7:0]              reg_rdata,
    input  wire logic               host_power_on,
    input  wire logic               button_press,
    input  wire logic               battery_low,
    input  wire logic               shutdown_done,
    output logic                    host_power_en,
    output logic                    host_halt_req,
    output indicator_pattern_t      indicator_pattern,
    output logic                    flash_busy
);
    logic tick;

    tick_divider #(
        .COUNT (TICK_COUNT)
    ) u_tick (
        .clock  (clock),
        .arst_n (arst_n),
        .tick   (tick)
    );

    // Pin synchronisers
    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 4'h0;
            sync_ff <= 4'h0;
        end else begin
            meta_ff <= {host_power_on, button_press, battery_low, shutdown_done};
            sync_ff <= meta_ff;
        end
    end
    logic pwr_s, btn_s, bat_s, done_s;
    assign {pwr_s, btn_s, bat_s, done_s} = sync_ff;

    logic btn_d_ff;
    logic btn_rise;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            btn_d_ff <= 1'b0;
        end else begin
            btn_d_ff <= btn_s;
        end
    end
    assign btn_rise = btn_s && !btn_d_ff;

    function automatic logic is_wr(input reg_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // Register and watchdog state
    logic [7:0] action_ff, nxt_action;
    logic [7:0] grace_ff, nxt_grace;
    logic [7:0] count_ff, nxt_count;
    logic       expired_ff, nxt_expired;
    logic       alert_ff, nxt_alert;
    logic       halt_ff, nxt_halt;
    logic       up_ff, nxt_up;
    logic       power_ff, nxt_power;
    logic       shut_ff, nxt_shut;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       enabled;
    logic       boot_report;

    assign enabled     = (action_ff != ACTION_OFF);
    assign boot_report = is_wr(reg_req, ADDR_HOST_UP) && (reg_req.wdata != ZERO_BYTE)
                         && !up_ff && power_ff && !shut_ff;

    always_comb begin
        nxt_action  = action_ff;
        nxt_grace   = grace_ff;
        nxt_count   = count_ff;
        nxt_expired = expired_ff;
        nxt_alert   = alert_ff;
        nxt_halt    = 1'b0;
        if (is_wr(reg_req, ADDR_ACTION_CFG)) begin
            nxt_action = reg_req.wdata;
        end
        if (is_wr(reg_req, ADDR_BOOT_GRACE)) begin
            nxt_grace = reg_req.wdata;
        end
        if (boot_report) begin
            nxt_count   = grace_ff; // R5
            nxt_expired = 1'b0;
            nxt_alert   = 1'b0;
        end else if (is_wr(reg_req, ADDR_COUNTDOWN)) begin
            nxt_count   = reg_req.wdata; // R6
            nxt_expired = 1'b0;
            nxt_alert   = 1'b0;
        end else if (enabled && tick && !expired_ff) begin // R2
            if (count_ff > 8'h01) begin
                nxt_count = count_ff - 8'h01; // R1
            end else begin
                // Zero reached: act once, then hold without wrap
                nxt_count   = 8'h00; // R17
                nxt_expired = 1'b1;
                if (action_ff == ACTION_ALERT) begin
                    nxt_alert = 1'b1; // R3
                end
                if (action_ff == ACTION_HOST_HALT) begin
                    nxt_halt = 1'b1; // R4
                end
            end
        end
        if (!enabled) begin
            nxt_alert = 1'b0;
        end
    end

    // Host power and running flag
    always_comb begin
        nxt_up    = up_ff;
        nxt_power = power_ff;
        nxt_shut  = shut_ff;
        if (pwr_s && !power_ff) begin
            nxt_power = 1'b1;
        end
        if (is_wr(reg_req, ADDR_HOST_UP) && power_ff && !shut_ff) begin
            nxt_up = (reg_req.wdata != ZERO_BYTE); // R9
            if (reg_req.wdata == ZERO_BYTE && up_ff) begin
                nxt_shut = 1'b1; // R13
            end
        end
        if (up_ff && (btn_rise || bat_s || halt_ff)) begin
            nxt_up   = 1'b0; // R10
            nxt_shut = 1'b1;
        end
        if (shut_ff && done_s) begin
            nxt_power = 1'b0; // R12
            nxt_shut  = 1'b0;
        end
        if (!power_ff) begin
            nxt_up = 1'b0; // R8
        end
    end

    // Persistent image commit
    logic       commit_ff, nxt_commit;
    logic [0:0] slot_ff, nxt_slot;
    logic       nv_we;
    logic [7:0] nv_wdata;
    logic [7:0] nv_rdata;

    always_comb begin
        nxt_commit = commit_ff;
        nxt_slot   = slot_ff;
        nv_we      = 1'b0;
        nv_wdata   = action_ff;
        if (commit_ff) begin
            nv_we    = 1'b1; // R16
            nv_wdata = (slot_ff == NV_SLOT_ACTION) ? action_ff : grace_ff;
            nxt_slot = slot_ff + 1'b1;
            if (slot_ff == NV_SLOT_GRACE) begin
                nxt_commit = 1'b0;
            end
        end else if (is_wr(reg_req, ADDR_FLASH_COMMIT)
                     && reg_req.wdata == COMMIT_MAGIC) begin // R14
            nxt_commit = 1'b1;
            nxt_slot   = NV_SLOT_ACTION;
        end
    end

    nv_store #(
        .DEPTH (NV_DEPTH)
    ) u_nv (
        .clock   (clock),
        .wr_en   (nv_we),
        .wr_addr (slot_ff),
        .wr_data (nv_wdata),
        .rd_addr (NV_SLOT_ACTION),
        .rd_data (nv_rdata)
    );

    always_comb begin
        nxt_rdata = ZERO_BYTE;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                ADDR_ACTION_CFG:   nxt_rdata = action_ff;
                ADDR_BOOT_GRACE:   nxt_rdata = grace_ff;
                ADDR_FLASH_COMMIT: nxt_rdata = ZERO_BYTE; // R15
                ADDR_COUNTDOWN:    nxt_rdata = count_ff;
                ADDR_HOST_UP:      nxt_rdata = {7'h00, up_ff};
                default:           nxt_rdata = ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            action_ff  <= RST_ACTION_CFG;
            grace_ff   <= RST_BOOT_GRACE;
            count_ff   <= 8'h00;
            expired_ff <= 1'b0;
            alert_ff   <= 1'b0;
            halt_ff    <= 1'b0;
            up_ff      <= 1'b0;
            power_ff   <= 1'b0;
            shut_ff    <= 1'b0;
            commit_ff  <= 1'b0;
            slot_ff    <= NV_SLOT_ACTION;
            rdata_ff   <= 8'h00;
        end else begin
            action_ff  <= nxt_action;
            grace_ff   <= nxt_grace;
            count_ff   <= nxt_count;
            expired_ff <= nxt_expired;
            alert_ff   <= nxt_alert;
            halt_ff    <= nxt_halt;
            up_ff      <= nxt_up;
            power_ff   <= nxt_power;
            shut_ff    <= nxt_shut;
            commit_ff  <= nxt_commit;
            slot_ff    <= nxt_slot;
            rdata_ff   <= nxt_rdata;
        end
    end

    // Output registers
    indicator_pattern_t pat_ff, nxt_pat;
    always_comb begin
        nxt_pat = PAT_PULSE; // R12
        if (up_ff) begin
            nxt_pat = PAT_STEADY; // R9
        end
        // Flash replaces only the running pattern; shutdown pulsing stays visible
        if (alert_ff && up_ff) begin
            nxt_pat = PAT_ERROR_FLASH; // R3
        end
    end

    logic power_o_ff, halt_o_ff, busy_o_ff;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pat_ff     <= PAT_PULSE;
            power_o_ff <= 1'b0;
            halt_o_ff  <= 1'b0;
            busy_o_ff  <= 1'b0;
        end else begin
            pat_ff     <= nxt_pat;
            power_o_ff <= nxt_power;
            halt_o_ff  <= nxt_shut;
            busy_o_ff  <= nxt_commit;
        end
    end

    assign reg_rdata         = rdata_ff;
    assign host_power_en     = power_o_ff;
    assign host_halt_req     = halt_o_ff;
    assign indicator_pattern = pat_ff;
    assign flash_busy        = busy_o_ff;

    AST_FROZEN_OFF: assert property (@(posedge clock) disable iff (!arst_n) // R2
        (action_ff == ACTION_OFF && !reg_req.wr) |=> $stable(count_ff))
        else $error("countdown moved while off");
    AST_DECREMENT: assert property (@(posedge clock) disable iff (!arst_n) // R1
        (enabled && tick && !reg_req.wr && count_ff > 8'h01)
        |=> count_ff == $past(count_ff) - 8'h01)
        else $error("countdown did not decrement");
    AST_ALERT: assert property (@(posedge clock) disable iff (!arst_n) // R3
        (action_ff == ACTION_ALERT && tick && !reg_req.wr && count_ff <= 8'h01 && !expired_ff)
        |=> alert_ff)
        else $error("alert not raised");
    AST_HALT: assert property (@(posedge clock) disable iff (!arst_n) // R4
        (action_ff == ACTION_HOST_HALT && tick && !reg_req.wr && count_ff <= 8'h01
         && !expired_ff) |=> halt_ff)
        else $error("halt not requested");
    AST_GRACE: assert property (@(posedge clock) disable iff (!arst_n) // R5
        boot_report |=> count_ff == $past(grace_ff))
        else $error("grace not loaded");
    AST_RESTART: assert property (@(posedge clock) disable iff (!arst_n) // R6
        (is_wr(reg_req, ADDR_COUNTDOWN) && !boot_report) |=> count_ff == $past(reg_req.wdata))
        else $error("countdown not restarted");
    AST_FLAG_OFF: assert property (@(posedge clock) disable iff (!arst_n) // R8
        !power_ff |=> !up_ff)
        else $error("flag set while power off");
    AST_BUTTON: assert property (@(posedge clock) disable iff (!arst_n) // R10
        (up_ff && btn_rise) |=> !up_ff && shut_ff)
        else $error("button did not clear flag");
    AST_SW_HALT: assert property (@(posedge clock) disable iff (!arst_n) // R13
        (up_ff && power_ff && !shut_ff && is_wr(reg_req, ADDR_HOST_UP)
         && reg_req.wdata == ZERO_BYTE) |=> ##1 host_halt_req)
        else $error("write of zero did not halt");
    AST_COMMIT: assert property (@(posedge clock) disable iff (!arst_n) // R14
        (!commit_ff && is_wr(reg_req, ADDR_FLASH_COMMIT) && reg_req.wdata != COMMIT_MAGIC)
        |=> !commit_ff)
        else $error("commit on wrong value");
    AST_READ_ZERO: assert property (@(posedge clock) disable iff (!arst_n) // R15
        (reg_req.rd && reg_req.addr == ADDR_FLASH_COMMIT) |=> reg_rdata == 8'h00)
        else $error("commit register read nonzero");
    AST_HOLD_ZERO: assert property (@(posedge clock) disable iff (!arst_n) // R17
        (expired_ff && !reg_req.wr) |=> count_ff == 8'h00)
        else $error("countdown wrapped");
    AST_PULSE_SHUT: assert property (@(posedge clock) disable iff (!arst_n) // R12
        shut_ff |=> indicator_pattern == PAT_PULSE)
        else $error("indicator not pulsing in shutdown");
    AST_NV_ACTION: assert property (@(posedge clock) disable iff (!arst_n) // R16
        (commit_ff && slot_ff == NV_SLOT_ACTION) |=> ##1 nv_rdata == $past(action_ff, 2))
        else $error("action not stored");

    COV_EXPIRE: cover property (@(posedge clock) disable iff (!arst_n) $rose(expired_ff));
    COV_RUNNING: cover property (@(posedge clock) disable iff (!arst_n) $rose(up_ff));
    COV_POWEROFF: cover property (@(posedge clock) disable iff (!arst_n) $fell(power_ff));
    COV_COMMIT: cover property (@(posedge clock) disable iff (!arst_n) $rose(commit_ff));
endmodule

// ===== sim/host_model.sv
// Host-side model: register accesses from host software and the shutdown handshake.
// Assumes the watchdog block on the same clock; requests change at falling edges.
`timescale 1ns/100ps
module host_model
    import wdog_pkg::*;
(
    input  wire logic clock,
    input  wire logic host_halt_req,
    input  wire logic host_power_en,
    output reg_req_t  reg_req,
    output logic      shutdown_done
);
    int halt_lag = 2;
    int lag_cnt  = 0;

    initial begin
        reg_req       = '0;
        shutdown_done = 1'b0;
    end

    // One strobe cycle, released at the next falling edge
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        reg_req = '{wr: wr, rd: ~wr, addr: addr, wdata: data};
        @(negedge clock);
        reg_req = '0;
    endtask

    // Halt lag lets the bench play a prompt or a slow host
    always @(negedge clock) begin
        if (!host_power_en) begin
            lag_cnt       <= 0;
            shutdown_done <= 1'b0;
        end else if (host_halt_req) begin
            lag_cnt <= lag_cnt + 1;
            if (lag_cnt >= halt_lag) shutdown_done <= 1'b1;
        end
    end
endmodule

// ===== sim/app_watchdog_power_flags_bench.sv
// Self-checking bench for the application watchdog and host power flags.
// Assumes the block with a 10-cycle tick and the host model on its register port.
`timescale 1ns/100ps
module app_watchdog_power_flags_bench;
    import wdog_pkg::*;
    localparam int PIN_POWER = 0;
    localparam int PIN_HALT  = 1;
    localparam int PIN_PAT   = 2;
    localparam int PIN_FLASH = 3;

    logic               clock         = 1'b0;
    logic               arst_n        = 1'b0;
    logic               host_power_on = 1'b0;
    logic               button_press  = 1'b0;
    logic               battery_low   = 1'b0;
    reg_req_t           reg_req;
    logic [7:0]         reg_rdata;
    logic               shutdown_done;
    logic               host_power_en;
    logic               host_halt_req;
    logic               flash_busy;
    logic               rd_seen;
    indicator_pattern_t indicator_pattern;
    logic [7:0]         exp_q[$];
    logic [7:0]         grace;
    int                 miscompares = 0;
    int                 num_checks  = 0;

    always #25 clock = ~clock;

    app_watchdog #(.TICK_COUNT(10)) dut (
        .clock(clock), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .host_power_on(host_power_on), .button_press(button_press),
        .battery_low(battery_low), .shutdown_done(shutdown_done),
        .host_power_en(host_power_en), .host_halt_req(host_halt_req),
        .indicator_pattern(indicator_pattern), .flash_busy(flash_busy)
    );

    host_model host (
        .clock(clock), .host_halt_req(host_halt_req), .host_power_en(host_power_en),
        .reg_req(reg_req), .shutdown_done(shutdown_done)
    );

    task automatic complete_run;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic compare_byte(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic compare_pin(string what, logic [1:0] exp, logic [1:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [1:0] pin(int k);
        case (k)
            PIN_POWER: return {1'b0, host_power_en};
            PIN_HALT:  return {1'b0, host_halt_req};
            PIN_PAT:   return indicator_pattern;
            default:   return {1'b0, flash_busy};
        endcase
    endfunction

    // Bounded wait; also checks that the change did not come too early
    task automatic wait_pin(string what, int k, logic [1:0] val, int lo, int hi);
        int n;
        n = 0;
        while (pin(k) !== val && n < hi) begin
            @(negedge clock);
            n++;
        end
        compare_pin(what, val, pin(k));
        if (pin(k) !== val) complete_run();
        compare_pin({what, " early"}, 2'd1, {1'b0, n >= lo});
    endtask

    task automatic wr(logic [7:0] addr, logic [7:0] data);
        host.access(1'b1, addr, data);
    endtask

    task automatic rd(logic [7:0] addr, logic [7:0] exp);
        exp_q.push_back(exp);
        host.access(1'b0, addr, 8'h00);
    endtask

    // Read data stands for the one cycle after the read strobe is taken
    always @(posedge clock) rd_seen <= reg_req.rd;
    always @(negedge clock) begin
        if (rd_seen === 1'b1 && exp_q.size() > 0) compare_byte("reg_rdata", exp_q.pop_front(), reg_rdata);
    end

    task automatic boot(logic [7:0] g);
        wr(ADDR_ACTION_CFG, ACTION_OFF);
        @(negedge clock);
        host_power_on = 1'b1;
        wait_pin("power on", PIN_POWER, 2'd1, 0, 10);
        rd(ADDR_HOST_UP, ZERO_BYTE);
        wr(ADDR_HOST_UP, 8'h01);
        wait_pin("steady", PIN_PAT, PAT_STEADY, 0, 4);
        rd(ADDR_HOST_UP, 8'h01);
        rd(ADDR_COUNTDOWN, g);
    endtask

    task automatic halt_by(int cause, int lag);
        host.halt_lag = lag;
        case (cause)
            0: begin
                @(negedge clock);
                button_press = 1'b1;
            end
            1: begin
                @(negedge clock);
                battery_low = 1'b1;
            end
            2: wr(ADDR_HOST_UP, ZERO_BYTE);
            default: begin
                wr(ADDR_ACTION_CFG, ACTION_HOST_HALT);
                wr(ADDR_COUNTDOWN, 8'h01);
            end
        endcase
        wait_pin("halt request", PIN_HALT, 2'd1, 0, 16);
        button_press  = 1'b0;
        battery_low   = 1'b0;
        host_power_on = 1'b0;
        rd(ADDR_HOST_UP, ZERO_BYTE);
        wait_pin("pulse", PIN_PAT, PAT_PULSE, 0, 4);
        wait_pin("power off", PIN_POWER, 2'd0, 0, lag + 14);
    endtask

    initial begin
        #3000000;
        miscompares++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h385c));
        repeat (2) @(negedge clock);
        arst_n = 1'b1;
        rd(ADDR_ACTION_CFG, RST_ACTION_CFG);
        rd(ADDR_BOOT_GRACE, RST_BOOT_GRACE);
        rd(ADDR_FLASH_COMMIT, ZERO_BYTE);
        rd(8'h26, ZERO_BYTE);
        wr(ADDR_HOST_UP, 8'h01);
        rd(ADDR_HOST_UP, ZERO_BYTE);
        boot(RST_BOOT_GRACE);
        repeat (30) @(negedge clock);
        rd(ADDR_COUNTDOWN, RST_BOOT_GRACE);
        wr(ADDR_ACTION_CFG, ACTION_ALERT);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_COUNTDOWN, 8'h02);
            repeat (5) @(negedge clock);
        end
        compare_pin("kept alive", PAT_STEADY, indicator_pattern);
        for (int v = 1; v <= 5; v += 2) begin
            wr(ADDR_COUNTDOWN, 8'(v));
            wait_pin("cleared", PIN_PAT, PAT_STEADY, 0, 4);
            wait_pin("expiry", PIN_PAT, PAT_ERROR_FLASH, 10 * v - 10, 10 * v + 6);
        end
        repeat (30) @(negedge clock);
        rd(ADDR_COUNTDOWN, ZERO_BYTE);
        grace = 8'($urandom_range(255, 1));
        wr(ADDR_BOOT_GRACE, grace);
        rd(ADDR_BOOT_GRACE, grace);
        wr(ADDR_FLASH_COMMIT, 8'h45);
        for (int i = 0; i < 4; i++) begin
            @(negedge clock);
            compare_pin("no commit", 2'd0, {1'b0, flash_busy});
        end
        wr(ADDR_FLASH_COMMIT, COMMIT_MAGIC);
        wait_pin("commit", PIN_FLASH, 2'd1, 0, 4);
        rd(ADDR_FLASH_COMMIT, ZERO_BYTE);
        for (int c = 0; c < 4; c++) begin
            halt_by(c, 2 + 8 * (c % 2));
            boot(grace);
        end
        complete_run();
    end
endmodule
